//--- inc/pts_pkg.sv
// Purpose: Constants and types shared by the proximity threshold block
// Assumes: Registers reached as I2C target bytes; sensor oscillator is a clock
// Notes:
// Operation
// - Lower threshold is two bytes: low byte at 04, high byte at 05.
// - Upper threshold is two bytes: low byte at 06, high byte at 07.
// - After reset lower threshold reads 0000, upper threshold reads FFFF.
// - Each integration lasts 2^n oscillator cycles, n being 4, 8, 12 or 16.
// - Resolution n comes from bits 3:2 of the second command register.
// - Oscillator nominally 725kHz, inversely scaled by the external resistor.
// - Mode bits 7:5 of first command register pick IR or proximity reading.
// - Any change of operating mode clears the persistence counter to zero.
// - Proximity LED drive is DC or 360kHz half duty, by bit 6.
// - LED current, 12.5 to 100mA in four steps, set by bits 5:4.
// - Detection runs three phases in series; LED on only in proximity phase.
// - Device answers only target address 1000100; host also tries 1000101 once.
// - Flag set, interrupt pin low after m out-of-window cycles; both stay.
// - Persistence codes 00, 01, 10, 11 give m of 1, 4, 8, 16.
// - Completed transfer of the first command register clears flag and pin.
// - Modes: 000 off, 010 IR once, 011 prox once, 110/111 continuous.
package pts_pkg;
  localparam logic [6:0] I2C_ADDR    = 7'h44;
  localparam logic [7:0] OFS_CMD1    = 8'h00;
  localparam logic [7:0] OFS_CMD2    = 8'h01;
  localparam logic [7:0] OFS_DLO     = 8'h02;
  localparam logic [7:0] OFS_DHI     = 8'h03;
  localparam logic [7:0] OFS_LTL     = 8'h04;
  localparam logic [7:0] OFS_LTH     = 8'h05;
  localparam logic [7:0] OFS_HTL     = 8'h06;
  localparam logic [7:0] OFS_HTH     = 8'h07;
  localparam int         MODE_MSB    = 7;
  localparam int         MODE_LSB    = 5;
  localparam int         FLAG_BIT    = 2;
  localparam int         LED_MODULATION_SELECT_BIT    = 6;
  localparam logic [7:0] CMD2_RST    = 8'h00;
  localparam logic [7:0] LT_RST      = 8'h00;
  localparam logic [7:0] HT_RST      = 8'hff;
  localparam logic [2:0] MODE_OFF    = 3'h0;
  localparam int         OSC_KHZ     = 725;
  localparam int         LED_MOD_KHZ = OSC_KHZ / 2;
  localparam int         RES_LEN_16  = 65536;
  localparam int         RES_LEN_12  = 4096;
  localparam int         RES_LEN_8   = 256;
  localparam int         RES_LEN_4   = 16;

  typedef struct packed {
    logic       wr;
    logic       done;
    logic [7:0] addr;
    logic [7:0] data;
  } pts_req_t;

  typedef struct packed {
    logic [2:0] mode;
    logic [1:0] res;
    logic       led_modulation_select;
  } pts_cfg_t;

  typedef enum logic [2:0] {I_IDLE, I_ADDR, I_PTR, I_WR, I_ACK, I_RD, I_RACK} pts_i2c_st_t;
  typedef enum logic [1:0] {OS_IDLE, OS_IR, OS_AMB, OS_PROX} pts_seq_st_t;

  function automatic logic [4:0] persist_m(input logic [1:0] code);
    unique case (code)
      2'h0: persist_m = 5'h01;
      2'h1: persist_m = 5'h04;
      2'h2: persist_m = 5'h08;
      2'h3: persist_m = 5'h10;
    endcase
  endfunction : persist_m
endpackage : pts_pkg

//--- rtl/pts_i2c_slave.sv
// Purpose: I2C target byte port onto the block registers
// Assumes: scl and sda are pins, resynchronised to clk
// Notes: Pointer byte after address, then auto-incrementing data bytes
`timescale 1ns/1ns
module pts_i2c_slave (
  // System
  input  wire logic             clk,
  input  wire logic             srst,
  // Pins
  input  wire logic             scl_i,
  input  wire logic             sda_i,
  output logic                  sda_o,
  output logic                  sda_oe,
  // Register side
  output pts_pkg::pts_req_t     req,
  output logic [7:0]            rd_addr,
  input  wire logic [7:0]       rd_data
);
  logic [2:0]          scl_s, sda_s;
  logic                scl_rise, scl_fall, start, stop;
  pts_pkg::pts_i2c_st_t st_reg, st_next, ret_reg, ret_next;
  logic [3:0]          cnt_reg, cnt_next;
  logic [7:0]          sh_reg, sh_next, ptr_reg, ptr_next;
  logic                oe_reg, oe_next, ack_reg, ack_next;
  pts_pkg::pts_req_t   req_reg, req_next;

  always_ff @(posedge clk) begin
    scl_s <= srst ? 3'h7 : {scl_s[1:0], scl_i};
    sda_s <= srst ? 3'h7 : {sda_s[1:0], sda_i};
  end

  assign scl_rise = scl_s[1] & ~scl_s[2];
  assign scl_fall = ~scl_s[1] & scl_s[2];
  assign start    = scl_s[1] & scl_s[2] & ~sda_s[1] & sda_s[2];
  assign stop     = scl_s[1] & scl_s[2] & sda_s[1] & ~sda_s[2];

  always_comb begin
    st_next       = st_reg;
    ret_next      = ret_reg;
    cnt_next      = cnt_reg;
    sh_next       = sh_reg;
    ptr_next      = ptr_reg;
    oe_next       = oe_reg;
    ack_next      = ack_reg;
    req_next      = '0;
    req_next.addr = ptr_reg;
    req_next.data = sh_reg;
    if (start) begin
      st_next  = pts_pkg::I_ADDR;
      cnt_next = 4'h0;
      oe_next  = 1'b0;
    end else if (stop) begin
      st_next = pts_pkg::I_IDLE;
      oe_next = 1'b0;
    end else begin
      unique case (st_reg)
        pts_pkg::I_IDLE: st_next = pts_pkg::I_IDLE;
        pts_pkg::I_ADDR, pts_pkg::I_PTR, pts_pkg::I_WR: begin
          if (scl_rise) begin
            sh_next  = {sh_reg[6:0], sda_s[1]};
            cnt_next = cnt_reg + 4'h1;
          end else if (scl_fall && cnt_reg == 4'h8) begin
            cnt_next = 4'h0;
            oe_next  = 1'b1;
            st_next  = pts_pkg::I_ACK;
            ret_next = pts_pkg::I_WR;
            if (st_reg == pts_pkg::I_ADDR) begin
              if (sh_reg[7:1] != pts_pkg::I2C_ADDR) begin
                st_next = pts_pkg::I_IDLE;
                oe_next = 1'b0;
              end else begin
                ret_next = sh_reg[0] ? pts_pkg::I_RD : pts_pkg::I_PTR;
              end
            end else if (st_reg == pts_pkg::I_PTR) begin
              ptr_next = sh_reg;
            end else begin
              req_next.wr   = 1'b1;
              req_next.done = 1'b1;
              ptr_next      = ptr_reg + 8'h01;
            end
          end
        end
        pts_pkg::I_ACK: if (scl_fall) begin
          st_next = ret_reg;
          oe_next = 1'b0;
          if (ret_reg == pts_pkg::I_RD) begin
            sh_next = rd_data;
            oe_next = ~rd_data[7];
          end
        end
        pts_pkg::I_RD: begin
          if (scl_rise) begin
            cnt_next = cnt_reg + 4'h1;
          end else if (scl_fall && cnt_reg == 4'h8) begin
            oe_next  = 1'b0;
            cnt_next = 4'h0;
            st_next  = pts_pkg::I_RACK;
          end else if (scl_fall) begin
            sh_next = {sh_reg[6:0], 1'b0};
            oe_next = ~sh_reg[6];
          end
        end
        pts_pkg::I_RACK: begin
          if (scl_rise) begin
            ack_next      = ~sda_s[1];
            req_next.done = 1'b1;
            ptr_next      = ptr_reg + 8'h01;
          end else if (scl_fall) begin
            st_next = ack_reg ? pts_pkg::I_RD : pts_pkg::I_IDLE;
            sh_next = rd_data;
            oe_next = ack_reg & ~rd_data[7];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg  <= pts_pkg::I_IDLE;
      ret_reg <= pts_pkg::I_WR;
      cnt_reg <= 4'h0;
      sh_reg  <= 8'h00;
      ptr_reg <= 8'h00;
      oe_reg  <= 1'b0;
      ack_reg <= 1'b0;
      req_reg <= '0;
    end else begin
      st_reg  <= st_next;
      ret_reg <= ret_next;
      cnt_reg <= cnt_next;
      sh_reg  <= sh_next;
      ptr_reg <= ptr_next;
      oe_reg  <= oe_next;
      ack_reg <= ack_next;
      req_reg <= req_next;
    end
  end

  assign sda_o   = 1'b0;
  assign sda_oe  = oe_reg;
  assign req     = req_reg;
  assign rd_addr = ptr_reg;

  a_addr_ack: assert property (@(posedge clk) disable iff (srst)
    st_reg == pts_pkg::I_ADDR ##1 st_reg == pts_pkg::I_ACK
    |-> $past(sh_reg[7:1]) == pts_pkg::I2C_ADDR)
    else $error("Acknowledged a foreign address");
endmodule : pts_i2c_slave

//--- rtl/pts_top.sv
// Purpose: Threshold interrupt and measurement sequencing of the sensor
// Assumes: adc_result is valid in the osc_clk domain at the end of a phase
// Notes: Register and interrupt logic on clk, sequencing on osc_clk
`timescale 1ns/1ns
module pts_top #(
  parameter int LEN_16 = pts_pkg::RES_LEN_16,
  parameter int LEN_12 = pts_pkg::RES_LEN_12
) (
  // System
  input  wire logic        clk,
  input  wire logic        srst,
  // Sensor oscillator domain
  input  wire logic        osc_clk,
  input  wire logic [15:0] adc_result,
  // I2C pins
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  // Sensor outputs
  output logic             int_n,
  output logic             led_drive_pin,
  output logic [1:0]       led_current_select
);
  ////////////////////////////////////////////////////////////////////////////
  // Register port
  pts_pkg::pts_req_t req;
  logic [7:0]        rd_addr, rd_data;

  pts_i2c_slave u_i2c (
    .clk     (clk),
    .srst    (srst),
    .scl_i   (scl_i),
    .sda_i   (sda_i),
    .sda_o   (sda_o),
    .sda_oe  (sda_oe),
    .req     (req),
    .rd_addr (rd_addr),
    .rd_data (rd_data)
  );

  logic [2:0]  mode_reg, mode_next;
  logic [1:0]  prst_reg, prst_next;
  logic [7:0]  cmd2_reg, cmd2_next;
  logic [15:0] lt_reg, lt_next, ht_reg, ht_next, data_reg, data_next;
  logic [4:0]  pcnt_reg, pcnt_next, m, inc;
  logic        flag_reg, flag_next, int_n_reg, tgl_reg, tgl_next;
  logic        mode_chg, res_ev, out_win, hit, clr, armed_reg, armed_next;
  logic [2:0]  res_s;
  logic [15:0] word_reg;
  logic        rtgl_reg;

  // Read mux, unmapped offsets read zero
  always_comb begin
    unique case (rd_addr)
      pts_pkg::OFS_CMD1: rd_data = {mode_reg, 2'b00, flag_reg, prst_reg};
      pts_pkg::OFS_CMD2: rd_data = cmd2_reg;
      pts_pkg::OFS_DLO:  rd_data = data_reg[7:0];
      pts_pkg::OFS_DHI:  rd_data = data_reg[15:8];
      pts_pkg::OFS_LTL:  rd_data = lt_reg[7:0];
      pts_pkg::OFS_LTH:  rd_data = lt_reg[15:8];
      pts_pkg::OFS_HTL:  rd_data = ht_reg[7:0];
      pts_pkg::OFS_HTH:  rd_data = ht_reg[15:8];
      default:           rd_data = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes and interrupt
  assign mode_chg = req.wr && req.addr == pts_pkg::OFS_CMD1 &&
                    req.data[pts_pkg::MODE_MSB:pts_pkg::MODE_LSB] != mode_reg;
  assign res_ev   = (res_s[1] ^ res_s[2]) && armed_reg; // Ignored until first mode write
  assign m        = pts_pkg::persist_m(prst_reg);
  assign inc      = pcnt_reg + 5'h01;
  assign out_win  = (word_reg < lt_reg) || (word_reg > ht_reg);
  assign hit      = res_ev && out_win && !mode_chg && inc >= m;
  assign clr      = req.done && req.addr == pts_pkg::OFS_CMD1;

  always_comb begin
    mode_next = mode_reg;
    prst_next = prst_reg;
    cmd2_next = cmd2_reg;
    lt_next   = lt_reg;
    ht_next   = ht_reg;
    tgl_next  = tgl_reg;
    armed_next = armed_reg || (req.wr && req.addr == pts_pkg::OFS_CMD1);
    if (req.wr) begin
      unique case (req.addr)
        pts_pkg::OFS_CMD1: begin
          mode_next = req.data[pts_pkg::MODE_MSB:pts_pkg::MODE_LSB];
          prst_next = req.data[1:0];
          if (mode_chg || !mode_next[2]) begin
            tgl_next = !tgl_reg;
          end
        end
        pts_pkg::OFS_CMD2: cmd2_next = req.data;
        pts_pkg::OFS_LTL:  lt_next[7:0]  = req.data;
        pts_pkg::OFS_LTH:  lt_next[15:8] = req.data;
        pts_pkg::OFS_HTL:  ht_next[7:0]  = req.data;
        pts_pkg::OFS_HTH:  ht_next[15:8] = req.data;
        default:           mode_next = mode_reg;
      endcase
    end
    if (mode_chg) begin
      pcnt_next = 5'h00;
    end else if (res_ev && out_win) begin
      pcnt_next = hit ? m : inc;
    end else if (res_ev) begin
      pcnt_next = 5'h00;
    end else begin
      pcnt_next = pcnt_reg;
    end
    data_next = res_ev ? word_reg : data_reg;
    flag_next = hit || (flag_reg && !clr);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mode_reg  <= pts_pkg::MODE_OFF;
      prst_reg  <= 2'h0;
      cmd2_reg  <= pts_pkg::CMD2_RST;
      lt_reg    <= {pts_pkg::LT_RST, pts_pkg::LT_RST};
      ht_reg    <= {pts_pkg::HT_RST, pts_pkg::HT_RST};
      data_reg  <= 16'h0000;
      pcnt_reg  <= 5'h00;
      flag_reg  <= 1'b0;
      int_n_reg <= 1'b1;
      tgl_reg   <= 1'b0;
      armed_reg <= 1'b0;
      res_s     <= 3'h0;
    end else begin
      mode_reg  <= mode_next;
      prst_reg  <= prst_next;
      cmd2_reg  <= cmd2_next;
      lt_reg    <= lt_next;
      ht_reg    <= ht_next;
      data_reg  <= data_next;
      pcnt_reg  <= pcnt_next;
      flag_reg  <= flag_next;
      int_n_reg <= !flag_next;
      tgl_reg   <= tgl_next;
      armed_reg <= armed_next;
      res_s     <= {res_s[1:0], rtgl_reg};
    end
  end

  assign int_n              = int_n_reg;
  assign led_current_select = cmd2_reg[5:4];

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator domain sequencer
  logic [1:0]           ors;
  logic                 osc_rst, start_ev, mod_reg, led_reg, led_next;
  logic                 rtgl_next;
  logic [2:0]           st_s;
  pts_pkg::pts_cfg_t    cfg_s1, cfg_s2;
  pts_pkg::pts_seq_st_t sq_reg, sq_next;
  logic [15:0]          icnt_reg, icnt_next, ir_reg, ir_next, word_next, last;

  function automatic logic [15:0] int_last(input logic [1:0] res);
    unique case (res)
      2'h0: int_last = 16'(LEN_16 - 1);
      2'h1: int_last = 16'(LEN_12 - 1);
      2'h2: int_last = 16'(pts_pkg::RES_LEN_8 - 1);
      2'h3: int_last = 16'(pts_pkg::RES_LEN_4 - 1);
    endcase
  endfunction : int_last

  always_ff @(posedge osc_clk) begin
    ors    <= {ors[0], srst};
    cfg_s1 <= {mode_reg, cmd2_reg[3:2], cmd2_reg[pts_pkg::LED_MODULATION_SELECT_BIT]};
    cfg_s2 <= cfg_s1;
    st_s   <= {st_s[1:0], tgl_reg};
  end

  assign osc_rst  = ors[1];
  assign start_ev = st_s[1] ^ st_s[2];
  assign last     = int_last(cfg_s2.res);

  always_comb begin
    sq_next   = sq_reg;
    icnt_next = (sq_reg == pts_pkg::OS_IDLE) ? 16'h0000 : icnt_reg + 16'h0001;
    ir_next   = ir_reg;
    word_next = word_reg;
    rtgl_next = rtgl_reg;
    if (start_ev) begin
      sq_next   = cfg_s2.mode[1] ? pts_pkg::OS_IR : pts_pkg::OS_IDLE;
      icnt_next = 16'h0000;
    end else if (icnt_reg == last) begin
      icnt_next = 16'h0000;
      unique case (sq_reg)
        pts_pkg::OS_IDLE: sq_next = pts_pkg::OS_IDLE;
        pts_pkg::OS_IR: begin
          ir_next = adc_result;
          sq_next = pts_pkg::OS_AMB;
        end
        pts_pkg::OS_AMB:  sq_next = pts_pkg::OS_PROX;
        pts_pkg::OS_PROX: begin
          word_next = cfg_s2.mode[0] ? adc_result : ir_reg;
          rtgl_next = !rtgl_reg;
          sq_next   = cfg_s2.mode[2] ? pts_pkg::OS_IR : pts_pkg::OS_IDLE;
        end
      endcase
    end
    led_next = sq_next == pts_pkg::OS_PROX && cfg_s2.mode[0] &&
               (!cfg_s2.led_modulation_select || !mod_reg);
  end

  always_ff @(posedge osc_clk) begin
    if (osc_rst) begin
      sq_reg   <= pts_pkg::OS_IDLE;
      icnt_reg <= 16'h0000;
      ir_reg   <= 16'h0000;
      word_reg <= 16'h0000;
      rtgl_reg <= 1'b0;
      mod_reg  <= 1'b0;
      led_reg  <= 1'b0;
    end else begin
      sq_reg   <= sq_next;
      icnt_reg <= icnt_next;
      ir_reg   <= ir_next;
      word_reg <= word_next;
      rtgl_reg <= rtgl_next;
      mod_reg  <= !mod_reg;
      led_reg  <= led_next;
    end
  end

  assign led_drive_pin = led_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_cmd1_wr;
    req.wr && req.addr == pts_pkg::OFS_CMD1;
  endsequence

  sequence s_out_hit;
    res_ev && out_win && inc >= m;
  endsequence

  a_thr_reset: assert property (@(posedge clk) disable iff (srst)
    $fell(srst) |-> lt_reg == 16'h0000 && ht_reg == 16'hffff)
    else $error("Threshold reset values wrong");
  a_lo_byte: assert property (@(posedge clk) disable iff (srst)
    req.wr && req.addr == pts_pkg::OFS_LTL |=> lt_reg[7:0] == $past(req.data))
    else $error("Lower threshold low byte not written");
  a_hi_byte: assert property (@(posedge clk) disable iff (srst)
    req.wr && req.addr == pts_pkg::OFS_HTH |=> ht_reg[15:8] == $past(req.data))
    else $error("Upper threshold high byte not written");
  a_mode_clear: assert property (@(posedge clk) disable iff (srst)
    s_cmd1_wr ##0 mode_chg |=> pcnt_reg == 5'h00)
    else $error("Persistence count kept across mode change");
  a_persist_set: assert property (@(posedge clk) disable iff (srst)
    s_out_hit ##0 !mode_chg |=> flag_reg && !int_n ##1 flag_reg || $past(clr))
    else $error("Flag not set after m out-of-window results");
  a_pin_flag: assert property (@(posedge clk) disable iff (srst)
    int_n == !flag_reg)
    else $error("Interrupt pin disagrees with flag");
  a_flag_clear: assert property (@(posedge clk) disable iff (srst)
    clr && !hit |=> !flag_reg && int_n)
    else $error("Flag not cleared by command transfer");
  a_led_phase: assert property (@(posedge osc_clk) disable iff (osc_rst)
    led_drive_pin |-> sq_reg == pts_pkg::OS_PROX)
    else $error("LED driven outside proximity phase");
  a_led_dc: assert property (@(posedge osc_clk) disable iff (osc_rst)
    sq_reg == pts_pkg::OS_PROX && cfg_s2.mode[0] && !cfg_s2.led_modulation_select && $stable(cfg_s2)
    |-> led_drive_pin)
    else $error("DC LED drive dropped");
  a_int_len: assert property (@(posedge osc_clk) disable iff (osc_rst)
    sq_reg != pts_pkg::OS_IDLE && !start_ev && icnt_reg != last
    |=> sq_reg == $past(sq_reg))
    else $error("Integration phase ended early");
endmodule : pts_top

//--- tb/pts_i2c_host.sv
// Purpose: I2C host model for the sensor register port
// Assumes: Bench resolves open-drain sda with a pull-up
// Notes: Bits change mid scl-low; all moves at falling clk
`timescale 1ns/1ns
module pts_i2c_host (
  // System
  input  wire logic clk,
  // Bus
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_rel
);
  localparam int HALF = 20;

  initial begin
    scl_o   = 1'b1;
    sda_rel = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic hw(input int n);
    repeat (n) @(negedge clk);
  endtask : hw

  // Also serves as repeated start from scl low
  task automatic start_c;
    sda_rel = 1'b1;
    hw(HALF);
    scl_o = 1'b1;
    hw(HALF);
    sda_rel = 1'b0;
    hw(HALF);
    scl_o = 1'b0;
  endtask : start_c

  task automatic stop_c;
    hw(HALF / 2);
    sda_rel = 1'b0;
    hw(HALF / 2);
    scl_o = 1'b1;
    hw(HALF);
    sda_rel = 1'b1;
    hw(HALF);
  endtask : stop_c

  // Eight bits plus acknowledge; a 1 releases the line
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      hw(HALF / 2);
      sda_rel = tx[i];
      hw(HALF / 2);
      scl_o = 1'b1;
      hw(HALF);
      rx[i] = sda_i;
      scl_o = 1'b0;
    end
  endtask : xfer

  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [6:0] a, input logic [7:0] ofs, input logic [7:0] d,
                    output logic ok);
    logic [8:0] r1;
    logic [8:0] r2;
    logic [8:0] r3;
    start_c;
    xfer({a, 2'b01}, r1);
    xfer({ofs, 1'b1}, r2);
    xfer({d, 1'b1}, r3);
    stop_c;
    ok = !r1[0] && !r2[0] && !r3[0];
  endtask : wr

  // Single byte read, closed by a not-acknowledge
  task automatic rd(input logic [6:0] a, input logic [7:0] ofs, output logic [7:0] d);
    logic [8:0] r;
    start_c;
    xfer({a, 2'b01}, r);
    xfer({ofs, 1'b1}, r);
    start_c;
    xfer({a, 2'b11}, r);
    xfer(9'h1ff, r);
    d = r[8:1];
    stop_c;
  endtask : rd
endmodule : pts_i2c_host

//--- tb/pts_top_tb.sv
// Purpose: Self-checking bench for the proximity threshold block
// Assumes: Resolution code 11 gives 16 osc cycles a phase, 600 clk a cycle
// Notes: Sensor oscillator at 125 ns, phase unrelated to clk
`timescale 1ns/1ns
module pts_top_tb;
  localparam logic [7:0] OFS_T [4] = '{pts_pkg::OFS_LTL, pts_pkg::OFS_LTH,
                                       pts_pkg::OFS_HTL, pts_pkg::OFS_HTH};
  localparam logic [7:0] RST_T [4] = '{pts_pkg::LT_RST, pts_pkg::LT_RST,
                                       pts_pkg::HT_RST, pts_pkg::HT_RST};
  localparam logic [7:0] NEW_T [4] = '{8'h00, 8'h01, 8'h00, 8'h02};

  logic        clk;
  logic        srst;
  logic        osc_clk;
  logic [15:0] adc_result;
  logic        scl;
  logic        sda_rel;
  wire         sda_w;
  logic        sda_o;
  logic        sda_oe;
  logic        int_n;
  logic        led_drive_pin;
  logic [1:0]  led_current_select;
  logic [7:0]  rd_v;
  logic        ok;
  int          err_count;
  int          total_checks;
  int          cyc;
  int          led_hi;
  int          led_rise;
  int          t0;

  // Open-drain sda with pull-up
  assign sda_w = sda_rel & ~(sda_oe & ~sda_o);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    osc_clk = 1'b0;
    #17;
    forever begin
      #62 osc_clk = 1'b1;
      #63 osc_clk = 1'b0;
    end
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (led_drive_pin === 1'b1)
      led_hi <= led_hi + 1;
  end

  always @(posedge led_drive_pin)
    led_rise <= led_rise + 1;

  ////////////////////////////////////////////////////////////////////////////
  pts_top #(.LEN_16(32), .LEN_12(16)) uut (
    .clk                (clk),
    .srst               (srst),
    .osc_clk            (osc_clk),
    .adc_result         (adc_result),
    .scl_i              (scl),
    .sda_i              (sda_w),
    .sda_o              (sda_o),
    .sda_oe             (sda_oe),
    .int_n              (int_n),
    .led_drive_pin      (led_drive_pin),
    .led_current_select (led_current_select)
  );

  pts_i2c_host host (
    .clk     (clk),
    .sda_i   (sda_w),
    .scl_o   (scl),
    .sda_rel (sda_rel)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic chk_rng(input int v, input int lo, input int hi, input string what);
    total_checks++;
    if (v < lo || v >= hi) begin
      err_count++;
      $display("CHECK FAILED t=%0t %s %0d outside %0d..%0d", $time, what, v, lo, hi);
    end
  endtask : chk_rng

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle

  task automatic done(input string name);
    $display("test %s finished at %0t", name, $time);
  endtask : done

  task automatic wr_reg(input logic [7:0] ofs, input logic [7:0] d);
    host.wr(pts_pkg::I2C_ADDR, ofs, d, ok);
    check({7'h00, ok}, 8'h01, "write not acknowledged");
  endtask : wr_reg

  task automatic rd_chk(input logic [7:0] ofs, input logic [7:0] exp);
    host.rd(pts_pkg::I2C_ADDR, ofs, rd_v);
    check(rd_v, exp, "register readback");
  endtask : rd_chk

  // Bounded wait for the interrupt, delay measured from a start cycle
  task automatic wait_int(input int lo, input int hi, input int since);
    while (int_n !== 1'b0 && cyc - since < hi)
      @(negedge clk);
    chk_rng(cyc - since, lo, hi, "interrupt delay");
    if (int_n !== 1'b0)
      report_and_stop;
  endtask : wait_int

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    $display("CHECK FAILED t=%0t run did not finish", $time);
    report_and_stop;
  end

  initial begin
    srst = 1'b1;
    adc_result = 16'h0000;
    repeat (10) @(negedge clk);
    srst = 1'b0;
    idle(5);
    host.wr(7'h45, pts_pkg::OFS_LTL, 8'h55, ok);
    check({7'h00, ok}, 8'h00, "foreign address acknowledged");
    for (int i = 0; i < 4; i++) begin
      rd_chk(OFS_T[i], RST_T[i]);
      wr_reg(OFS_T[i], NEW_T[i]);
      rd_chk(OFS_T[i], NEW_T[i]);
    end
    rd_chk(pts_pkg::OFS_CMD1, 8'h00);
    rd_chk(8'h0a, 8'h00);
    done("registers");
    // Current levels, ending at 100 mA, modulated, 16-cycle integration
    for (int c = 0; c < 4; c++) begin
      wr_reg(pts_pkg::OFS_CMD2, {2'b01, c[1:0], 4'b1100});
      check({6'h00, led_current_select}, {6'h00, c[1:0]}, "led current");
    end
    done("led current");
    // Above upper threshold, persistence 4, proximity continuous
    adc_result = 16'h0201;
    wr_reg(pts_pkg::OFS_CMD1, 8'he1);
    wait_int(2000, 2800, cyc);
    led_hi = 0;
    led_rise = 0;
    idle(1200);
    chk_rng(led_rise, 14, 19, "led pulses");
    chk_rng(led_hi, 180, 221, "led on time");
    adc_result = 16'h0200;
    idle(700);
    check({7'h00, int_n}, 8'h00, "interrupt not held");
    rd_chk(pts_pkg::OFS_CMD1, 8'he5);
    idle(2);
    check({7'h00, int_n}, 8'h01, "read did not clear");
    idle(1300);
    check({7'h00, int_n}, 8'h01, "edge value out of window");
    rd_chk(pts_pkg::OFS_DLO, 8'h00);
    done("persistence");
    // Below lower threshold, persistence 1
    adc_result = 16'h00ff;
    wr_reg(pts_pkg::OFS_CMD1, 8'he0);
    wait_int(0, 800, cyc);
    done("lower threshold");
    // Mode changes clear the persistence count
    wr_reg(pts_pkg::OFS_CMD1, 8'hc3);
    check({7'h00, int_n}, 8'h01, "write did not clear");
    led_hi = 0;
    idle(2000);
    chk_rng(led_hi, 0, 3, "led in infrared mode");
    wr_reg(pts_pkg::OFS_CMD1, 8'he3);
    t0 = cyc;
    for (int i = 0; i < 4; i++)
      wr_reg(OFS_T[i], NEW_T[i]);
    wait_int(9200, 10200, t0);
    done("mode change");
    // DC drive at 100 mA, 32-cycle phases from the shortened 16-bit setting
    wr_reg(pts_pkg::OFS_CMD2, 8'h30);
    led_hi = 0;
    led_rise = 0;
    idle(2400);
    chk_rng(led_hi, 780, 821, "dc led on time");
    chk_rng(led_rise, 1, 4, "dc led pulses");
    done("dc drive");
    report_and_stop;
  end
endmodule : pts_top_tb
